//--- core/rff_filter.sv
// receive frame filter with automatic and slotted acknowledgement timing
// Notes on behaviour
// RULE_01: unfiltered reserved upload: frame end, no match
// RULE_02: filtered reserved frames treated as data frames
// RULE_03: filtered reserved: ack only after frame end
// RULE_04: reserved upload off discards reserved frames
// RULE_05: ack delay twelve or two symbols
// RULE_06: slotted trigger allowed two symbols after frame
// RULE_07: reserved frame types rejected by default
// RULE_08: reserved version rejected, relaxable by setting
// RULE_09: version accept field picks acknowledged versions
// RULE_10: destination pan must match or broadcast
// RULE_11: destination short or long address must match
// RULE_12: beacon source pan must match unless broadcast
// RULE_13: source-only frames need coordinator and pan
// RULE_14: reject ack frames and addressless frames
// RULE_15: no match event for dst<=1, src=0
// RULE_16: passing frame raises match event when enabled
// RULE_17: slotted mode holds ack until trigger edge
// RULE_18: slotted mode sets ack wait code
// RULE_19: host times trigger edge for slot start
// RULE_20: ack starts 16 us after trigger edge
// RULE_21: corrupted frames get no ack or frame end
module rff_filter
  import rff_pkg::*;
#(
  parameter int ACK_STD_CYC   = ACK_STD_CYCLES,    // standard ack wait, cycles
  parameter int ACK_SHORT_CYC = ACK_SHORT_CYCLES,  // reduced ack wait, cycles
  parameter int TRIG_TX_CYC   = TRIG_TO_TX_CYCLES  // trigger to transmit, cycles
) (
  input  wire logic       i_clock,
  input  wire logic       i_rstn,
  input  wire logic       i_ce,
  input  wire rff_bus_t   i_bus,
  output logic      [7:0] o_rdata,
  input  wire logic       i_frame_done,
  input  wire rff_hdr_t   i_hdr,
  input  wire logic       i_trigger_pin,
  input  wire logic       i_match_irq_en,
  output logic            o_frame_end_event,
  output logic            o_addr_match_event,
  output logic            o_ack_tx_start,
  output logic      [2:0] o_transaction_result
);

  // configuration registers
  logic [7:0]  rx_protection_ctrl_r;   // frame protection control
  logic [7:0]  ext_ack_ctrl_1_r;       // reserved type and ack timing bits
  logic [7:0]  ext_ack_ctrl_0_r;       // slotted operation bit
  logic [7:0]  ack_policy_seed_r;      // coordinator, ack disable, version policy
  logic [15:0] short_address_r;        // node short address
  logic [15:0] pan_id_r;               // node pan identifier
  logic [7:0]  long_address_r [8];     // node 64-bit address, byte wise
  logic [63:0] long_address;           // flattened view of the long address

  // decoded control bits
  logic       reserved_type_upload_en;
  logic       reserved_type_filter_en;
  logic       pan_coordinator_flag;
  logic       ack_gen_disable;
  logic [1:0] frame_version_accept_sel;
  logic       ack_delay_short;
  logic       slotted_en;

  assign reserved_type_upload_en  = ext_ack_ctrl_1_r[BIT_RES_UPLOAD];
  assign reserved_type_filter_en  = ext_ack_ctrl_1_r[BIT_RES_FILTER];
  assign ack_delay_short          = ext_ack_ctrl_1_r[BIT_ACK_DELAY_SHORT];
  assign slotted_en               = ext_ack_ctrl_0_r[BIT_SLOTTED];
  assign pan_coordinator_flag     = ack_policy_seed_r[BIT_PAN_COORD];
  assign ack_gen_disable          = ack_policy_seed_r[BIT_ACK_DISABLE];
  assign frame_version_accept_sel = ack_policy_seed_r[BIT_FVN_LO +: 2];

  // flatten long address bytes, byte 0 least significant
  genvar g;
  generate
    for (g = 0; g < 8; g++) begin : g_long
      assign long_address[g*8 +: 8] = long_address_r[g];
    end
  endgenerate

  // ack sequencer states
  typedef enum logic [1:0] {
    ST_IDLE  = 2'b00,  // waiting for a frame
    ST_DELAY = 2'b01,  // counting the ack turnaround
    ST_WAIT  = 2'b10,  // slotted: waiting for the trigger edge
    ST_TRIG  = 2'b11   // counting trigger to transmit
  } rff_state_t;

  rff_state_t  state_r;
  logic [15:0] count_r;        // shared cycle counter
  logic        slot_pending_r; // slotted delay reached, ack due

  // trigger pin synchroniser, three stages
  logic trig_s1_r;
  logic trig_s2_r;
  logic trig_s3_r;
  logic trig_level_r;   // debounced level, changes when stage two and three agree
  logic trig_rise;

  // register writes
  always_ff @(posedge i_clock or negedge i_rstn) begin
    if (!i_rstn) begin
      rx_protection_ctrl_r <= RST_ZERO;
      ext_ack_ctrl_1_r     <= RST_ZERO;
      ext_ack_ctrl_0_r     <= RST_ZERO;
      ack_policy_seed_r    <= RST_POLICY;
      short_address_r      <= BCAST;
      pan_id_r             <= BCAST;
      for (int i = 0; i < 8; i++) begin
        long_address_r[i] <= RST_LONG_ADDR;
      end
    end else if (i_ce && i_bus.wr) begin
      unique case (i_bus.addr)
        REG_RX_PROTECTION_CTRL: rx_protection_ctrl_r  <= i_bus.wdata;
        REG_EXT_ACK_CTRL_1:     ext_ack_ctrl_1_r      <= i_bus.wdata;
        REG_EXT_ACK_CTRL_0:     ext_ack_ctrl_0_r      <= i_bus.wdata;
        REG_ACK_POLICY_SEED:    ack_policy_seed_r     <= i_bus.wdata;
        REG_SHORT_ADDRESS_LOW:  short_address_r[7:0]  <= i_bus.wdata;
        REG_SHORT_ADDRESS_HIGH: short_address_r[15:8] <= i_bus.wdata;
        REG_PAN_ID_LOW:         pan_id_r[7:0]         <= i_bus.wdata;
        REG_PAN_ID_HIGH:        pan_id_r[15:8]        <= i_bus.wdata;
        default: begin
          // long address bytes sit in a contiguous block
          if (i_bus.addr >= REG_LONG_ADDRESS_BYTE0 && i_bus.addr <= REG_LONG_ADDRESS_BYTE7) begin
            long_address_r[3'(i_bus.addr - REG_LONG_ADDRESS_BYTE0)] <= i_bus.wdata;
          end
        end
      endcase
    end
  end

  // register reads, data valid the cycle after the strobe; unmapped reads as zero
  always_ff @(posedge i_clock or negedge i_rstn) begin
    if (!i_rstn) begin
      o_rdata <= RST_ZERO;
    end else if (i_ce) begin
      if (i_bus.rd) begin
        unique case (i_bus.addr)
          REG_RX_PROTECTION_CTRL: o_rdata <= rx_protection_ctrl_r;
          REG_EXT_ACK_CTRL_1:     o_rdata <= ext_ack_ctrl_1_r;
          REG_EXT_ACK_CTRL_0:     o_rdata <= ext_ack_ctrl_0_r;
          REG_ACK_POLICY_SEED:    o_rdata <= ack_policy_seed_r;
          REG_SHORT_ADDRESS_LOW:  o_rdata <= short_address_r[7:0];
          REG_SHORT_ADDRESS_HIGH: o_rdata <= short_address_r[15:8];
          REG_PAN_ID_LOW:         o_rdata <= pan_id_r[7:0];
          REG_PAN_ID_HIGH:        o_rdata <= pan_id_r[15:8];
          // status: slotted ack pending, sequencer state, transaction result
          REG_STATUS:             o_rdata <= {2'h0, slot_pending_r, state_r, o_transaction_result};
          default: begin
            if (i_bus.addr >= REG_LONG_ADDRESS_BYTE0 &&
                i_bus.addr <= REG_LONG_ADDRESS_BYTE7) begin
              o_rdata <= long_address_r[3'(i_bus.addr - REG_LONG_ADDRESS_BYTE0)];
            end else begin
              o_rdata <= RST_ZERO;
            end
          end
        endcase
      end else begin
        o_rdata <= RST_ZERO;
      end
    end
  end

  // ---------------- filter decision, combinational over the parsed header
  logic is_reserved;     // frame type 4..7
  logic version_ok;      // version accepted by policy
  logic dst_pan_ok;
  logic dst_addr_ok;
  logic beacon_ok;
  logic src_only_ok;
  logic addr_present;
  logic filter_pass;     // third level filter result
  logic reserved_bypass; // reserved frame uploaded unfiltered
  logic match_allowed;   // match event not suppressed
  logic frame_end_ok;
  logic match_ok;
  logic ack_due;

  always_comb begin
    is_reserved = i_hdr.frame_type[2];
    // version policy also relaxes the reserved version check
    unique case (frame_version_accept_sel)
      2'h0:    version_ok = (i_hdr.frame_version == 2'h0);  // RULE_09
      2'h1:    version_ok = (i_hdr.frame_version <= 2'h1);  // RULE_08
      2'h2:    version_ok = (i_hdr.frame_version <= 2'h2);
      default: version_ok = 1'b1;
    endcase
    dst_pan_ok = (i_hdr.dst_mode == AM_NONE) ||
                 (i_hdr.dst_pan == pan_id_r) || (i_hdr.dst_pan == BCAST);  // RULE_10
    unique case (i_hdr.dst_mode)
      AM_SHORT: dst_addr_ok = (i_hdr.dst_addr[15:0] == short_address_r) ||
                              (i_hdr.dst_addr[15:0] == BCAST);  // RULE_11
      AM_LONG:  dst_addr_ok = (i_hdr.dst_addr == long_address);  // RULE_11
      default:  dst_addr_ok = 1'b1;
    endcase
    beacon_ok = (i_hdr.frame_type != FT_BEACON) || (pan_id_r == BCAST) ||
                (i_hdr.src_pan == pan_id_r);  // RULE_12
    // data, command and filtered reserved frames with source fields only
    src_only_ok = !((i_hdr.frame_type == FT_DATA || i_hdr.frame_type == FT_CMD ||
                     is_reserved) &&
                    i_hdr.dst_mode == AM_NONE && i_hdr.src_mode != AM_NONE) ||
                  (pan_coordinator_flag && i_hdr.src_pan == pan_id_r);  // RULE_13
    addr_present = (i_hdr.dst_mode != AM_NONE) || (i_hdr.src_mode != AM_NONE);
    filter_pass = (!is_reserved || (reserved_type_upload_en && reserved_type_filter_en)) &&
                  version_ok && dst_pan_ok && dst_addr_ok && beacon_ok && src_only_ok &&
                  (i_hdr.frame_type != FT_ACK) && addr_present;  // RULE_07 RULE_14 RULE_02
    reserved_bypass = is_reserved && reserved_type_upload_en &&
                      !reserved_type_filter_en;  // RULE_01
    // a frame with no real destination and no source is never announced
    match_allowed = !((i_hdr.dst_mode == AM_NONE || i_hdr.dst_mode == 2'h1) &&
                      i_hdr.src_mode == AM_NONE);  // RULE_15
    match_ok = filter_pass && match_allowed && !reserved_bypass;  // RULE_01 RULE_16
    // reserved with upload off never passes: silently dropped
    frame_end_ok = i_hdr.fcs_ok && (filter_pass || reserved_bypass);  // RULE_04 RULE_21
    ack_due = frame_end_ok && filter_pass && i_hdr.ack_request &&
              !ack_gen_disable;  // RULE_03 RULE_21
  end

  // frame end and address match pulses, one cycle each
  always_ff @(posedge i_clock or negedge i_rstn) begin
    if (!i_rstn) begin
      o_frame_end_event  <= 1'b0;
      o_addr_match_event <= 1'b0;
    end else if (i_ce) begin
      o_frame_end_event  <= i_frame_done && frame_end_ok;  // RULE_02
      o_addr_match_event <= i_frame_done && match_ok && i_match_irq_en;  // RULE_16
    end
  end

  // trigger pin synchroniser; stage one feeds only stage two
  always_ff @(posedge i_clock or negedge i_rstn) begin
    if (!i_rstn) begin
      trig_s1_r    <= 1'b0;
      trig_s2_r    <= 1'b0;
      trig_s3_r    <= 1'b0;
      trig_level_r <= 1'b0;
    end else if (i_ce) begin
      trig_s1_r <= i_trigger_pin;
      trig_s2_r <= trig_s1_r;
      trig_s3_r <= trig_s2_r;
      if (trig_s2_r == trig_s3_r) begin
        trig_level_r <= trig_s3_r;
      end
    end
  end

  assign trig_rise = (trig_s2_r == trig_s3_r) && trig_s3_r && !trig_level_r;

  // ack sequencer: delay, slotted hold, trigger to transmit
  always_ff @(posedge i_clock or negedge i_rstn) begin
    if (!i_rstn) begin
      state_r              <= ST_IDLE;
      count_r              <= 16'h0000;
      slot_pending_r       <= 1'b0;
      o_ack_tx_start       <= 1'b0;
      o_transaction_result <= TRAC_INVALID;
    end else if (i_ce) begin
      o_ack_tx_start <= 1'b0;
      unique case (state_r)
        ST_IDLE: begin
          if (i_frame_done && ack_due) begin
            state_r <= ST_DELAY;
            // slotted mode waits two symbols before it may be triggered
            if (slotted_en || ack_delay_short) begin
              count_r <= 16'(ACK_SHORT_CYC - 1);  // RULE_05 RULE_06
            end else begin
              count_r <= 16'(ACK_STD_CYC - 1);  // RULE_05
            end
          end
        end
        ST_DELAY: begin
          if (count_r != 16'h0000) begin
            count_r <= count_r - 16'h0001;
          end else if (slotted_en) begin
            state_r              <= ST_WAIT;  // RULE_17
            slot_pending_r       <= 1'b1;
            o_transaction_result <= TRAC_ACK_WAIT;  // RULE_18
          end else begin
            state_r              <= ST_IDLE;
            o_ack_tx_start       <= 1'b1;
            o_transaction_result <= TRAC_SUCCESS;
          end
        end
        ST_WAIT: begin
          // host owns the slot timing of the edge
          if (trig_rise) begin  // RULE_19
            state_r <= ST_TRIG;
            count_r <= 16'(TRIG_TX_CYC - 1);  // RULE_20
          end
        end
        ST_TRIG: begin
          if (count_r != 16'h0000) begin
            count_r <= count_r - 16'h0001;
          end else begin
            state_r              <= ST_IDLE;
            slot_pending_r       <= 1'b0;
            o_ack_tx_start       <= 1'b1;  // RULE_20
            o_transaction_result <= TRAC_SUCCESS;
          end
        end
      endcase
    end
  end

endmodule : rff_filter

//--- core/rff_pkg.sv
// package of register map, field positions and timing constants for the receive frame filter
package rff_pkg;

  // register byte offsets
  localparam logic [7:0] REG_RX_PROTECTION_CTRL = 8'h0C;
  localparam logic [7:0] REG_EXT_ACK_CTRL_1     = 8'h17;
  localparam logic [7:0] REG_SHORT_ADDRESS_LOW  = 8'h20;
  localparam logic [7:0] REG_SHORT_ADDRESS_HIGH = 8'h21;
  localparam logic [7:0] REG_PAN_ID_LOW         = 8'h22;
  localparam logic [7:0] REG_PAN_ID_HIGH        = 8'h23;
  localparam logic [7:0] REG_LONG_ADDRESS_BYTE0 = 8'h24;
  localparam logic [7:0] REG_LONG_ADDRESS_BYTE7 = 8'h2B;
  localparam logic [7:0] REG_EXT_ACK_CTRL_0     = 8'h2C;
  localparam logic [7:0] REG_ACK_POLICY_SEED    = 8'h2E;
  localparam logic [7:0] REG_STATUS             = 8'h30;

  // field positions
  localparam int BIT_RX_PROTECT      = 7;
  localparam int BIT_ACK_DELAY_SHORT = 2;
  localparam int BIT_RES_UPLOAD      = 4;
  localparam int BIT_RES_FILTER      = 5;
  localparam int BIT_SLOTTED         = 0;
  localparam int BIT_PAN_COORD       = 3;
  localparam int BIT_ACK_DISABLE     = 4;
  localparam int BIT_FVN_LO          = 6;

  // reset values
  localparam logic [7:0] RST_ZERO      = 8'h00;
  localparam logic [7:0] RST_POLICY    = 8'h40;
  localparam logic [7:0] RST_LONG_ADDR = 8'h00;

  // frame types and address modes
  localparam logic [2:0] FT_BEACON = 3'h0;
  localparam logic [2:0] FT_DATA   = 3'h1;
  localparam logic [2:0] FT_ACK    = 3'h2;
  localparam logic [2:0] FT_CMD    = 3'h3;
  localparam logic [1:0] AM_NONE   = 2'h0;
  localparam logic [1:0] AM_SHORT  = 2'h2;
  localparam logic [1:0] AM_LONG   = 2'h3;
  localparam logic [15:0] BCAST    = 16'hFFFF;

  // transaction result codes
  localparam logic [2:0] TRAC_SUCCESS  = 3'h0;
  localparam logic [2:0] TRAC_ACK_WAIT = 3'h2;
  localparam logic [2:0] TRAC_INVALID  = 3'h7;

  // timing
  localparam int CLK_MHZ            = 100;
  localparam int SYMBOL_US          = 16;
  localparam int ACK_STD_SYMBOLS    = 12;
  localparam int ACK_SHORT_SYMBOLS  = 2;
  localparam int TRIG_TO_TX_US      = 16;
  localparam int SYMBOL_CYCLES      = SYMBOL_US * CLK_MHZ;
  localparam int ACK_STD_CYCLES     = ACK_STD_SYMBOLS * SYMBOL_CYCLES;
  localparam int ACK_SHORT_CYCLES   = ACK_SHORT_SYMBOLS * SYMBOL_CYCLES;
  localparam int TRIG_TO_TX_CYCLES  = TRIG_TO_TX_US * CLK_MHZ;

  // parsed header handed over by the receive path at frame end
  typedef struct packed {
    logic [2:0]  frame_type;
    logic        ack_request;
    logic        pan_compress;
    logic [1:0]  dst_mode;
    logic [1:0]  frame_version;
    logic [1:0]  src_mode;
    logic [15:0] dst_pan;
    logic [63:0] dst_addr;
    logic [15:0] src_pan;
    logic        fcs_ok;
  } rff_hdr_t;

  // register bus request
  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
  } rff_bus_t;

endpackage : rff_pkg

//--- tb/rff_filter_props.sv
// assertion checker for the receive frame filter, seeing only its ports
module rff_filter_props
  import rff_pkg::*;
#(
  parameter int TRIG_TX_CYC = TRIG_TO_TX_CYCLES  // trigger to transmit, cycles
) (
  input wire logic       i_clock,
  input wire logic       i_rstn,
  input wire logic       i_ce,
  input wire rff_bus_t   i_bus,
  input wire logic [7:0] o_rdata,
  input wire logic       i_frame_done,
  input wire rff_hdr_t   i_hdr,
  input wire logic       i_trigger_pin,
  input wire logic       i_match_irq_en,
  input wire logic       o_frame_end_event,
  input wire logic       o_addr_match_event,
  input wire logic       o_ack_tx_start,
  input wire logic [2:0] o_transaction_result
);
  timeunit 1ns;
  timeprecision 1ps;

  // pin path goes through a synchroniser, so the start window is a small band
  localparam int TLO = TRIG_TX_CYC + 2;  // earliest start after pin rise
  localparam int THI = TRIG_TX_CYC + 6;  // latest start after pin rise

  default clocking cb @(posedge i_clock); endclocking
  default disable iff (!i_rstn);

  rdata_idle_a: assert property (!$past(i_bus.rd) |-> o_rdata == 8'h00)
    else $error("read data not zero outside read answer");
  ack_type_a: assert property (i_frame_done && i_hdr.frame_type == FT_ACK
    |=> !o_frame_end_event && !o_addr_match_event) else $error("ack frame accepted");
  corrupt_end_a: assert property (i_frame_done && !i_hdr.fcs_ok
    |=> !o_frame_end_event) else $error("corrupted frame signalled");
  mode_nomatch_a: assert property (i_frame_done && i_hdr.dst_mode <= 2'h1
    && i_hdr.src_mode == AM_NONE |=> !o_addr_match_event) else $error("match on no address");
  irq_gate_a: assert property (i_frame_done && !i_match_irq_en
    |=> !o_addr_match_event) else $error("match event while disabled");
  event_cause_a: assert property ((o_frame_end_event || o_addr_match_event)
    |-> $past(i_frame_done)) else $error("event without a frame");
  ack_result_a: assert property (o_ack_tx_start |=> o_transaction_result == TRAC_SUCCESS)
    else $error("result not success after ack");
  trig_hold_a: assert property (o_ack_tx_start && $past(o_transaction_result) ==
    TRAC_ACK_WAIT |-> $past(i_trigger_pin, 3)) else $error("slotted ack without trigger");
  trig_delay_a: assert property ($rose(i_trigger_pin) &&
    o_transaction_result == TRAC_ACK_WAIT |-> ##[TLO:THI] o_ack_tx_start)
    else $error("ack not started after trigger");
endmodule : rff_filter_props

//--- tb/rff_host_model.sv
// host and receive-path model: frame hand-over pulses and the slotted trigger pin
module rff_host_model
  import rff_pkg::*;
(
  input  wire logic i_clock,
  output logic      o_frame_done,
  output rff_hdr_t  o_hdr,
  output logic      o_trigger_pin
);
  timeunit 1ns;
  timeprecision 1ps;

  // idle levels at time zero
  initial begin
    o_frame_done  = 1'b0;
    o_hdr         = '0;
    o_trigger_pin = 1'b0;
  end

  // one-cycle frame pulse; header scrambled afterwards so stale data is never trusted
  task automatic send(input rff_hdr_t h);
    @(posedge i_clock);
    o_frame_done <= 1'b1;
    o_hdr        <= h;
    @(posedge i_clock);
    o_frame_done <= 1'b0;
    o_hdr        <= ~h;
  endtask : send

  // the host alone decides the slot instant, held long enough to be synchronised
  task automatic trigger();
    @(posedge i_clock);
    o_trigger_pin <= 1'b1;
    repeat (10) @(posedge i_clock);
    o_trigger_pin <= 1'b0;
  endtask : trigger
endmodule : rff_host_model

//--- tb/tb_top.sv
// self-checking bench for the receive frame filter
module tb_top
  import rff_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  localparam logic [15:0] P = 16'hABCD;  // node pan id
  localparam logic [15:0] S = 16'h1234;  // node short address
  typedef struct packed {
    logic [7:0] c17;
    logic [7:0] c2e;
    rff_hdr_t   h;
    logic [1:0] ev;   // {frame end, address match}
  } rff_row_t;

  logic       i_clock, i_rstn, i_frame_done, i_trigger_pin, seen;
  logic       ce, match_en;   // clock enable and match event enable under test
  rff_bus_t   i_bus;
  rff_hdr_t   i_hdr;
  logic [7:0] o_rdata;
  logic       o_frame_end_event, o_addr_match_event, o_ack_tx_start;
  logic [2:0] o_transaction_result;
  int         bad_count, checks_done, cycles;
  rff_row_t   rows[$];
  logic [15:0] rv[10] = '{16'h2E40, 16'h1700, 16'h2C00, 16'h0C00, 16'h20FF,
                         16'h23FF, 16'h2400, 16'h2B00, 16'h3000, 16'h0500};

  // small counts keep the run short; expectations below follow them
  rff_filter #(.ACK_STD_CYC(24), .ACK_SHORT_CYC(4), .TRIG_TX_CYC(3)) rff_filter_i (
    .i_clock(i_clock), .i_rstn(i_rstn), .i_ce(ce), .i_bus(i_bus), .o_rdata(o_rdata),
    .i_frame_done(i_frame_done), .i_hdr(i_hdr), .i_trigger_pin(i_trigger_pin),
    .i_match_irq_en(match_en), .o_frame_end_event(o_frame_end_event),
    .o_addr_match_event(o_addr_match_event), .o_ack_tx_start(o_ack_tx_start),
    .o_transaction_result(o_transaction_result));
  rff_host_model host_i (.i_clock(i_clock), .o_frame_done(i_frame_done), .o_hdr(i_hdr),
    .o_trigger_pin(i_trigger_pin));

  // clock and hang guard
  initial begin
    i_clock = 1'b0;
    forever #5 i_clock = ~i_clock;
  end
  always @(posedge i_clock) begin
    cycles++;
    if (cycles == 6000) begin
      bad_count++;
      print_verdict();
    end
  end

  task automatic print_verdict();
    if (bad_count == 0 && checks_done > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : print_verdict
  task automatic chk_bit(input string n, input logic e, input logic g);
    checks_done++;
    if (g !== e) begin
      bad_count++;
      $display("[ERR] %s expected %b seen %b", n, e, g);
    end
  endtask : chk_bit
  task automatic chk_byte(input string n, input logic [7:0] e, input logic [7:0] g);
    checks_done++;
    if (g !== e) begin
      bad_count++;
      $display("[ERR] %s expected %h seen %h", n, e, g);
    end
  endtask : chk_byte
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge i_clock);
    i_bus <= '{a, d, 1'b1, 1'b0};
    @(posedge i_clock);
    i_bus.wr <= 1'b0;
  endtask : wr
  task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
    @(posedge i_clock);
    i_bus <= '{a, 8'h00, 1'b0, 1'b1};
    @(posedge i_clock);
    i_bus.rd <= 1'b0;
    @(negedge i_clock);
    chk_byte("rdata", e, o_rdata);
  endtask : rd_chk
  // reset asserted and released on rising edges only
  task automatic rst();
    @(posedge i_clock);
    i_rstn <= 1'b0;
    repeat (3) @(posedge i_clock);
    i_rstn <= 1'b1;
  endtask : rst
  task automatic reset_cfg();
    rst();
    wr(REG_SHORT_ADDRESS_LOW, S[7:0]);
    wr(REG_SHORT_ADDRESS_HIGH, S[15:8]);
    wr(REG_PAN_ID_LOW, P[7:0]);
    wr(REG_PAN_ID_HIGH, P[15:8]);
  endtask : reset_cfg
  function automatic rff_hdr_t mk(logic [2:0] ft, logic [1:0] dm, logic [15:0] dp, da,
      logic [1:0] sm = AM_NONE, logic [15:0] sp = 16'h0000, logic [1:0] ver = 2'h0);
    return '{ft, 1'b1, 1'b0, dm, ver, sm, dp, {48'h0, da}, sp, 1'b1};
  endfunction : mk
  function automatic void r(logic [2:0] ft, logic [1:0] dm, logic [15:0] dp, da,
      logic [1:0] ev, logic [1:0] sm = AM_NONE, logic [15:0] sp = 16'h0000,
      logic [1:0] ver = 2'h0, logic [7:0] c2e = 8'h50, logic [7:0] c17 = 8'h00);
    rows.push_back('{c17, c2e, mk(ft, dm, dp, da, sm, sp, ver), ev});
  endfunction : r
  // watch a stretch of cycles for any acknowledgement start
  task automatic watch(input int n);
    seen = 1'b0;
    repeat (n) begin
      @(negedge i_clock);
      seen |= o_ack_tx_start;
    end
  endtask : watch
  task automatic ack_time(input logic [7:0] c17, input logic [7:0] e);
    int k;
    k = 0;
    wr(REG_EXT_ACK_CTRL_1, c17);
    host_i.send(mk(FT_DATA, AM_SHORT, P, S));
    do begin
      @(negedge i_clock);
      k++;
    end while (o_ack_tx_start !== 1'b1 && k < 60);
    chk_byte("ack_delay", e, k[7:0]);
    @(negedge i_clock);
    chk_byte("result", {5'h00, TRAC_SUCCESS}, {5'h00, o_transaction_result});
  endtask : ack_time
  task automatic no_ack(input logic [7:0] c17, input rff_hdr_t h);
    wr(REG_EXT_ACK_CTRL_1, c17);
    host_i.send(h);
    watch(30);
    chk_bit("no_ack", 1'b0, seen);
  endtask : no_ack

  initial begin
    rff_hdr_t h;
    i_rstn   = 1'b0;
    i_bus    = '0;
    ce       = 1'b1;
    match_en = 1'b1;
    // filter cases: ack generation disabled so no sequencer overlaps the next row
    r(FT_DATA, AM_SHORT, P, S, 2'h3);
    r(FT_DATA, AM_SHORT, P, 16'h1235, 2'h0);
    r(FT_DATA, AM_SHORT, P, BCAST, 2'h3);
    r(FT_DATA, AM_SHORT, 16'h1111, S, 2'h0);
    r(FT_DATA, AM_SHORT, BCAST, S, 2'h3);
    r(FT_CMD, AM_LONG, P, 16'h0000, 2'h3);
    r(FT_DATA, AM_LONG, P, 16'h0001, 2'h0);
    r(FT_BEACON, AM_NONE, P, S, 2'h3, AM_SHORT, P);
    r(FT_BEACON, AM_NONE, P, S, 2'h0, AM_SHORT, 16'h1111);
    r(FT_ACK, AM_NONE, P, S, 2'h0);
    r(FT_DATA, AM_NONE, P, S, 2'h3, AM_SHORT, P, 2'h0, 8'h58);
    r(FT_DATA, AM_NONE, P, S, 2'h0, AM_SHORT, P, 2'h0, 8'h50);
    r(FT_DATA, AM_NONE, P, S, 2'h0);
    r(FT_DATA, AM_SHORT, P, S, 2'h0, AM_NONE, 16'h0000, 2'h2);
    r(FT_DATA, AM_SHORT, P, S, 2'h3, AM_NONE, 16'h0000, 2'h2, 8'h90);
    r(FT_DATA, AM_SHORT, P, S, 2'h0, AM_NONE, 16'h0000, 2'h1, 8'h10);
    r(FT_DATA, AM_SHORT, P, S, 2'h3, AM_NONE, 16'h0000, 2'h3, 8'hD0);
    r(3'h4, AM_SHORT, P, S, 2'h0);
    r(3'h5, AM_SHORT, P, 16'h1235, 2'h2, AM_NONE, 16'h0000, 2'h0, 8'h50, 8'h10);
    r(3'h4, AM_SHORT, P, S, 2'h3, AM_NONE, 16'h0000, 2'h0, 8'h50, 8'h30);
    r(3'h4, AM_SHORT, P, 16'h1235, 2'h0, AM_NONE, 16'h0000, 2'h0, 8'h50, 8'h30);
    reset_cfg();
    foreach (rows[k]) begin
      wr(REG_EXT_ACK_CTRL_1, rows[k].c17);
      wr(REG_ACK_POLICY_SEED, rows[k].c2e);
      host_i.send(rows[k].h);
      @(negedge i_clock);
      chk_bit("frame_end", rows[k].ev[1], o_frame_end_event);
      chk_bit("addr_match", rows[k].ev[0], o_addr_match_event);
    end
    // match event disabled: frame still ends, no match announced; left off from here
    @(posedge i_clock);
    match_en <= 1'b0;
    host_i.send(mk(FT_DATA, AM_SHORT, P, S));
    @(negedge i_clock);
    chk_bit("frame_end", 1'b1, o_frame_end_event);
    chk_bit("addr_match", 1'b0, o_addr_match_event);
    // mid-run reset: register defaults, status, unmapped place, frozen write
    rst();
    wr(8'h05, 8'hA5);
    wr(REG_STATUS, 8'h5A);
    @(posedge i_clock);
    ce <= 1'b0;
    wr(REG_RX_PROTECTION_CTRL, 8'h80);
    ce <= 1'b1;
    foreach (rv[k]) rd_chk(rv[k][15:8], (rv[k][15:8] == REG_STATUS) ? 8'h07 : rv[k][7:0]);
    reset_cfg();
    wr(REG_RX_PROTECTION_CTRL, 8'h80);
    rd_chk(REG_RX_PROTECTION_CTRL, 8'h80);
    // acknowledgement timing: standard then reduced delay
    ack_time(8'h00, 8'h19);
    ack_time(8'h04, 8'h05);
    h = mk(FT_DATA, AM_SHORT, P, S);
    h.fcs_ok = 1'b0;
    no_ack(8'h00, h);
    no_ack(8'h10, mk(3'h5, AM_SHORT, P, S));
    no_ack(8'h30, mk(3'h4, AM_SHORT, P, 16'h1235));
    // slotted acknowledgement held for the host trigger
    wr(REG_EXT_ACK_CTRL_1, 8'h00);
    wr(REG_EXT_ACK_CTRL_0, 8'h01);
    host_i.send(mk(FT_DATA, AM_SHORT, P, S));
    repeat (4) @(negedge i_clock);
    chk_bit("ack_wait", 1'b0, o_transaction_result === TRAC_ACK_WAIT);
    @(negedge i_clock);
    chk_bit("ack_wait", 1'b1, o_transaction_result === TRAC_ACK_WAIT);
    watch(30);
    chk_bit("ack_held", 1'b0, seen);
    rd_chk(REG_STATUS, 8'h32);
    fork
      host_i.trigger();
      watch(15);
    join
    chk_bit("ack_trig", 1'b1, seen);
    print_verdict();
  end
endmodule : tb_top

bind rff_filter rff_filter_props #(.TRIG_TX_CYC(TRIG_TX_CYC)) rff_filter_props_i (
  .i_clock(i_clock), .i_rstn(i_rstn), .i_ce(i_ce), .i_bus(i_bus), .o_rdata(o_rdata),
  .i_frame_done(i_frame_done), .i_hdr(i_hdr), .i_trigger_pin(i_trigger_pin),
  .i_match_irq_en(i_match_irq_en), .o_frame_end_event(o_frame_end_event),
  .o_addr_match_event(o_addr_match_event), .o_ack_tx_start(o_ack_tx_start),
  .o_transaction_result(o_transaction_result));
